// ### src/mux_read_pkg.sv
`default_nettype none
// ****************************************************************
// shared constants and carriers for the multiplexed read sequencer
// ****************************************************************
package mux_read_pkg;
    localparam int ADDR_W = 16;                       // multiplexed address/data width
    localparam int PHASE_W = 4;                       // width of each phase count
    localparam logic [PHASE_W-1:0] ADDR_PHASE_MIN = 4'h2;    // least address count
    localparam logic [PHASE_W-1:0] SETUP_PHASE_MIN = 4'h2;   // least setup count
    localparam logic [PHASE_W-1:0] STROBE_PHASE_MIN = 4'h1;  // least strobe count
    localparam logic [PHASE_W-1:0] RECOV_PHASE_MIN = 4'h1;   // least recovery count
    localparam logic [PHASE_W-1:0] STROBE_PHASE_MAX = 4'h4;  // strobe pulse at most 5 cycles when no wait holds it
    localparam logic [PHASE_W-1:0] CAPTURE_DELAY = 4'h4;     // cycles from strobe fall to capture
    localparam logic [PHASE_W-1:0] SYNC_LATENCY = 4'h4;      // pin to filtered level, cycles
    localparam logic [PHASE_W-1:0] CAPTURE_POINT = CAPTURE_DELAY + SYNC_LATENCY; // capture count
    localparam logic [PHASE_W-1:0] SYNC_RESET = 4'h0;        // cleared counter value

    // phase counts programmed by software
    typedef struct packed {
        logic [PHASE_W-1:0] address_phase_count;
        logic [PHASE_W-1:0] data_setup_phase_count;
        logic [PHASE_W-1:0] data_strobe_phase_count;
        logic [PHASE_W-1:0] recovery_phase_count;
    } phase_cfg_t;

    // pin-facing outputs toward the dsp
    typedef struct packed {
        logic cs_n;
        logic host_data_strobe_n;
        logic [ADDR_W-1:0] ad_out;
        logic ad_oe;
    } dsp_pins_t;

    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_SETUP, ST_STROBE, ST_RECOV} seq_state_t;
endpackage : mux_read_pkg
`default_nettype wire

// ### src/pin_sync3.sv
`default_nettype none
// ****************************************************************
// three-stage synchroniser, output moves once stages two and three agree
// ****************************************************************
module pin_sync3
    import mux_read_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic pin_in,
    output logic level_out
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } sync_state_t;

    sync_state_t st_q; // registered state
    sync_state_t st_d; // next state

    // shift chain, stable level taken when the last two stages agree
    always_comb
    begin
        st_d = st_q;
        st_d.s1 = pin_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        if (st_q.s2 == st_q.s3)
        begin
            st_d.lvl = st_q.s3;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign level_out = st_q.lvl;
endmodule : pin_sync3
`default_nettype wire

// ### src/mux_read_seq.sv
`default_nettype none
// ****************************************************************
// multiplexed 16-bit read sequencer toward a dsp host port
// ****************************************************************

// Overview of operation
// [RQ1] all counts in expansion clock cycles
// [RQ2] address driven with chip select
// [RQ3] address held 11 to 45 cycles; the address phase here lasts 3 to 16 cycles, longer only under wait
// [RQ4] address count at least 2, three cycles
// [RQ5] hold address one cycle past wait
// [RQ6] setup count at least 2, three cycles
// [RQ7] strobe count at least 1, two cycles
// [RQ8] hold setup one cycle past wait
// [RQ9] dsp may stall access any time
// [RQ10] no exit address/strobe while waiting
// [RQ11] strobe follows chip select by phases
// [RQ12] strobe low at most five cycles; longer here only under wait
// [RQ13] capture data four cycles after fall
// [RQ14] recovery gap of 2 to 17 cycles
// [RQ15] recovery count sets idle gap
// [RQ16] fixed phase order, release before recovery
module mux_read_seq
    import mux_read_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic rd_req,
    input wire logic [ADDR_W-1:0] rd_addr,
    input wire phase_cfg_t phase_cfg,
    input wire logic dsp_ready_wait,
    input wire logic [ADDR_W-1:0] ad_in,
    output logic rd_busy,
    output logic rd_done,
    output logic [ADDR_W-1:0] rd_data,
    output logic cs_n,
    output logic host_data_strobe_n,
    output logic [ADDR_W-1:0] ad_out,
    output logic ad_oe
);
    // ****************************************************************
    // state
    // ****************************************************************
    // one struct holds all state; the comb block fills a copy of it
    // and the clocked block registers that copy
    typedef struct packed {
        seq_state_t state;
        logic [PHASE_W-1:0] cnt;       // cycles left in phase
        logic [PHASE_W-1:0] cap_cnt;   // cycles since strobe fall
        logic cap_pend;                // capture still owed
        logic waited;                  // wait seen in this phase
        logic [ADDR_W-1:0] addr;       // latched address
        dsp_pins_t pins;               // registered pin drive
        logic busy;
        logic done;
        logic [ADDR_W-1:0] data;
    } seq_t;

    seq_t st_q; // registered state
    seq_t st_d; // next state
    logic wait_sync; // synchronised wait level
    logic [ADDR_W-1:0] ad_sync; // synchronised read data

    // ****************************************************************
    // phase count helpers
    // ****************************************************************

    // clamp a phase count to its floor
    function automatic logic [PHASE_W-1:0] at_least(input logic [PHASE_W-1:0] v,
                                                    input logic [PHASE_W-1:0] lo);
        at_least = (v < lo) ? lo : v;
    endfunction : at_least

    // clamp a phase count to its ceiling
    function automatic logic [PHASE_W-1:0] at_most(input logic [PHASE_W-1:0] v,
                                                   input logic [PHASE_W-1:0] hi);
        at_most = (v > hi) ? hi : v;
    endfunction : at_most

    // true while cycles remain in the current phase
    function automatic logic phase_left(input logic [PHASE_W-1:0] v);
        phase_left = (v != SYNC_RESET);
    endfunction : phase_left

    // one cycle off a phase count
    function automatic logic [PHASE_W-1:0] step_down(input logic [PHASE_W-1:0] v);
        step_down = v - 4'h1;
    endfunction : step_down

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    // the wait pin is filtered before any phase decision reads it
    pin_sync3 u_wait_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .pin_in(dsp_ready_wait),
        .level_out(wait_sync)
    );

    // read data lines pass the same three-stage filter; a new level shows
    // four cycles after it reaches the pins, which the capture point allows for
    genvar gi;
    generate
        for (gi = 0; gi < ADDR_W; gi++)
        begin : g_ad_sync
            pin_sync3 u_ad_sync (
                .ref_clk(ref_clk),
                .rst_b(rst_b),
                .pin_in(ad_in[gi]),
                .level_out(ad_sync[gi])
            );
        end
    endgenerate

    // ****************************************************************
    // phase sequencer, one step per expansion clock
    // ****************************************************************
    // a phase loaded with count n lasts n+1 cycles: the count runs down to
    // zero and the phase ends on the cycle that finds it there
    always_comb
    begin
        st_d = st_q;
        st_d.done = 1'b0;
        // capture timer runs from the strobe falling edge; the data filter
        // lags the pins, so the compare point adds the filter latency
        if (st_q.cap_pend)
        begin
            if (st_q.cap_cnt == CAPTURE_POINT)
            begin
                // filtered level now shows the lines four cycles after the fall
                st_d.data = ad_sync; // RQ13
                st_d.cap_pend = 1'b0;
                st_d.done = 1'b1;
            end
            else
            begin
                // still short of the capture point
                st_d.cap_cnt = st_q.cap_cnt + 4'h1; // RQ1
            end
        end
        unique case (st_q.state)
            ST_IDLE:
            begin
                // accept a request, drive address with chip select
                if (rd_req)
                begin
                    st_d.addr = rd_addr;
                    st_d.pins.cs_n = 1'b0; // RQ2
                    st_d.pins.ad_out = rd_addr; // RQ2
                    st_d.pins.ad_oe = 1'b1;
                    st_d.busy = 1'b1;
                    st_d.waited = 1'b0;
                    // count n gives n+1 cycles in the phase
                    st_d.cnt = at_least(phase_cfg.address_phase_count, ADDR_PHASE_MIN); // RQ4 RQ3
                    st_d.state = ST_ADDR;
                end
                // nothing else moves while idle
            end

            ST_ADDR:
            begin
                // filtered wait high: hold the address phase
                if (wait_sync)
                begin
                    st_d.waited = 1'b1; // RQ9 RQ10
                end
                // wait just dropped: one more cycle before counting on
                else if (st_q.waited)
                begin
                    st_d.waited = 1'b0; // RQ5 one extra cycle after release
                end
                // cycles left: run the count down
                else if (phase_left(st_q.cnt))
                begin
                    st_d.cnt = step_down(st_q.cnt); // RQ1
                end
                // count spent, no wait pending
                else
                begin
                    // release address, turn lines round for read data
                    st_d.pins.ad_oe = 1'b0;
                    st_d.cnt = at_least(phase_cfg.data_setup_phase_count, SETUP_PHASE_MIN); // RQ6
                    st_d.state = ST_SETUP;
                end
            end

            ST_SETUP:
            begin
                // filtered wait high: hold the setup phase
                if (wait_sync)
                begin
                    st_d.waited = 1'b1; // RQ8
                end
                // wait just dropped: one more cycle before counting on
                else if (st_q.waited)
                begin
                    st_d.waited = 1'b0; // RQ8
                end
                // cycles left: run the count down
                else if (phase_left(st_q.cnt))
                begin
                    st_d.cnt = step_down(st_q.cnt);
                end
                // count spent: the strobe falls
                else
                begin
                    // strobe falls only after the address and setup phases
                    st_d.pins.host_data_strobe_n = 1'b0; // RQ11
                    st_d.cap_pend = 1'b1;
                    st_d.cap_cnt = 4'h1;
                    st_d.cnt = at_least(phase_cfg.data_strobe_phase_count, STROBE_PHASE_MIN); // RQ7
                    // pulse capped whatever the programmed count
                    st_d.cnt = at_most(st_d.cnt, STROBE_PHASE_MAX); // RQ12
                    st_d.state = ST_STROBE;
                end
            end

            ST_STROBE:
            begin
                // note a stall seen while the strobe is low
                if (wait_sync)
                begin
                    st_d.waited = 1'b1; // RQ10 stall held off below
                end
                // pulse width counts on regardless of the stall
                if (phase_left(st_q.cnt))
                begin
                    st_d.cnt = step_down(st_q.cnt); // RQ12 pulse bounded
                end
                // count spent: leave only once the wait has cleared
                else if (!wait_sync)
                begin
                    // release strobe and chip select before recovery
                    st_d.pins.host_data_strobe_n = 1'b1; // RQ16
                    st_d.pins.cs_n = 1'b1; // RQ16
                    st_d.waited = 1'b0;
                    st_d.cnt = at_least(phase_cfg.recovery_phase_count, RECOV_PHASE_MIN); // RQ14
                    st_d.state = ST_RECOV;
                end
            end

            ST_RECOV:
            begin
                // idle gap set by the recovery count
                if (phase_left(st_q.cnt))
                begin
                    st_d.cnt = step_down(st_q.cnt); // RQ15
                end
                // gap over: free only once the read word is in
                else if (!st_q.cap_pend)
                begin
                    st_d.busy = 1'b0; // RQ14
                    st_d.state = ST_IDLE;
                end
            end

            default:
            begin
                // undefined state code: release the bus and fall back to idle
                st_d.pins.cs_n = 1'b1;
                st_d.pins.host_data_strobe_n = 1'b1;
                st_d.pins.ad_oe = 1'b0;
                st_d.waited = 1'b0;
                st_d.cap_pend = 1'b0;
                st_d.busy = 1'b0;
                st_d.state = ST_IDLE;
            end
        endcase
    end

    // registered state, synchronous active-low reset
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            // everything cleared, then the pins parked released
            st_q <= '0;
            st_q.state <= ST_IDLE;
            st_q.pins.cs_n <= 1'b1;
            st_q.pins.host_data_strobe_n <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ****************************************************************
    // outputs, all straight from flip-flops
    // ****************************************************************
    // handshake and read word toward the requester
    assign rd_busy = st_q.busy;
    assign rd_done = st_q.done;
    assign rd_data = st_q.data;
    // pin drive toward the dsp
    assign cs_n = st_q.pins.cs_n;
    assign host_data_strobe_n = st_q.pins.host_data_strobe_n;
    assign ad_out = st_q.pins.ad_out;
    assign ad_oe = st_q.pins.ad_oe;
endmodule : mux_read_seq
`default_nettype wire

// ### tb/mux_read_checker.sv
`default_nettype none
// ****
// timing checks on the sequencer pins
// ****
module mux_read_checker
    import mux_read_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic rd_req,
    input wire logic [ADDR_W-1:0] rd_addr,
    input wire logic dsp_ready_wait,
    input wire logic rd_busy,
    input wire logic rd_done,
    input wire logic cs_n,
    input wire logic host_data_strobe_n,
    input wire logic [ADDR_W-1:0] ad_out,
    input wire logic ad_oe
);
    logic [7:0] cs_cnt_q; // cycles select low
    logic [7:0] st_cnt_q; // cycles strobe low
    logic wt_q; // wait seen in strobe
    // helper counters
    always_ff @(posedge ref_clk)
    begin
        cs_cnt_q <= cs_n ? 8'h00 : cs_cnt_q + 8'h01;
        st_cnt_q <= host_data_strobe_n ? 8'h00 : st_cnt_q + 8'h01;
        wt_q <= !host_data_strobe_n && (wt_q || dsp_ready_wait);
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    a_addr_with_cs: assert property (rd_req && !rd_busy |=>
        !cs_n && ad_oe && ad_out == $past(rd_addr)) else $error("no address with select");
    a_addr_three: assert property ($fell(cs_n) |-> ad_oe [*3])
        else $error("address phase short");
    a_setup_three: assert property ($fell(ad_oe) |-> host_data_strobe_n [*3])
        else $error("setup phase short");
    a_strobe_after_cs: assert property ($fell(host_data_strobe_n) |->
        !cs_n && cs_cnt_q >= 8'h06) else $error("strobe too early");
    a_strobe_width: assert property ($rose(host_data_strobe_n) |->
        st_cnt_q >= 8'h02 && (st_cnt_q <= 8'h05 || wt_q)) else $error("strobe width");
    a_capture_delay: assert property ($fell(host_data_strobe_n) |-> ##8 rd_done)
        else $error("no capture");
    a_release_order: assert property ($rose(host_data_strobe_n) |->
        $rose(cs_n) && !ad_oe) else $error("release order");
    a_recov_gap: assert property ($rose(cs_n) |-> cs_n [*2])
        else $error("recovery short");
    a_wait_addr: assert property ((ad_oe && dsp_ready_wait) [*5] |=> ad_oe)
        else $error("left address in wait");
    a_wait_setup: assert property ((!ad_oe && !cs_n && host_data_strobe_n
        && dsp_ready_wait) [*5] |=> host_data_strobe_n) else $error("left setup in wait");
endmodule : mux_read_checker
bind mux_read_seq mux_read_checker i_chk (.ref_clk(ref_clk), .rst_b(rst_b),
    .rd_req(rd_req), .rd_addr(rd_addr), .dsp_ready_wait(dsp_ready_wait),
    .rd_busy(rd_busy), .rd_done(rd_done), .cs_n(cs_n), .ad_oe(ad_oe),
    .host_data_strobe_n(host_data_strobe_n), .ad_out(ad_out));
`default_nettype wire

// ### tb/dsp_port_model.sv
`default_nettype none
// ****
// dsp host port: stalls and read data
// ****
module dsp_port_model
    import mux_read_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic cs_n,
    input wire logic host_data_strobe_n,
    input wire logic [ADDR_W-1:0] word,
    input wire logic [3:0] wait_len,
    output logic dsp_ready_wait,
    output logic [ADDR_W-1:0] ad_in
);
    logic cs_q; // last select
    logic st_q; // last strobe
    logic [3:0] w_q; // stall cycles left
    logic [3:0] h_q; // hold cycles left
    logic [ADDR_W-1:0] junk_q; // changing filler
    // stall after select falls, hold data after strobe falls
    always_ff @(posedge ref_clk)
    begin
        cs_q <= cs_n || !rst_b;
        st_q <= host_data_strobe_n || !rst_b;
        junk_q <= rst_b ? junk_q + 16'h3c5b : 16'h0000;
        w_q <= !rst_b ? 4'h0 : (cs_q && !cs_n) ? wait_len : w_q - {3'h0, |w_q};
        h_q <= !rst_b ? 4'h0 : (st_q && !host_data_strobe_n) ? 4'hc : h_q - {3'h0, |h_q};
    end
    assign dsp_ready_wait = |w_q;
    // read word shows only from the fourth cycle after the strobe fall,
    // the latest the port may bring it, and filler before and after
    assign ad_in = (|h_q && h_q <= 4'ha) ? word : ~junk_q;
endmodule : dsp_port_model
`default_nettype wire

// ### tb/testbench.sv
`default_nettype none
module testbench
    import mux_read_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic rd_req = 1'b0;
    logic [ADDR_W-1:0] rd_addr = 16'h0000;
    phase_cfg_t phase_cfg = 16'h2211;
    logic [ADDR_W-1:0] word = 16'h0000;
    logic [3:0] wait_len = 4'h0;
    logic dsp_ready_wait, rd_busy, rd_done, cs_n, host_data_strobe_n, ad_oe;
    logic [ADDR_W-1:0] ad_in, rd_data, ad_out;
    logic [ADDR_W-1:0] exp_q[$]; // expected read words
    int miscompares = 0;
    int samples_checked = 0;
    int seed = 40;
    mux_read_seq i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .rd_req(rd_req),
        .rd_addr(rd_addr), .phase_cfg(phase_cfg), .dsp_ready_wait(dsp_ready_wait),
        .ad_in(ad_in), .rd_busy(rd_busy), .rd_done(rd_done), .rd_data(rd_data),
        .cs_n(cs_n), .host_data_strobe_n(host_data_strobe_n), .ad_out(ad_out), .ad_oe(ad_oe));
    dsp_port_model i_dsp (.ref_clk(ref_clk), .rst_b(rst_b), .cs_n(cs_n),
        .host_data_strobe_n(host_data_strobe_n), .word(word), .wait_len(wait_len),
        .dsp_ready_wait(dsp_ready_wait), .ad_in(ad_in));
    task automatic check(input logic [ADDR_W-1:0] seen, input logic [ADDR_W-1:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t read %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test;
        if (miscompares == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test
    function automatic logic [3:0] rnd(input int lo, input int hi);
        return 4'(lo + ($unsigned($random(seed)) % (hi - lo + 1)));
    endfunction : rnd
    // one read with fresh counts; odd reads add an ignored request
    task automatic do_read(input int i);
        phase_cfg_t c;
        logic [ADDR_W-1:0] w;
        int n;
        n = 0;
        c = '{rnd(2, 15), rnd(2, 15), rnd(1, 15), rnd(1, 15)};
        if (i == 0) c = '{4'h2, 4'h2, 4'h1, 4'h1};
        if (i == 1) c = '{4'hf, 4'hf, 4'h4, 4'hf};
        w = $random(seed);
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (rd_busy !== 1'b0 && n < 300);
        rd_req <= 1'b1;
        rd_addr <= $random(seed);
        phase_cfg <= c;
        word <= w;
        wait_len <= (i % 3 == 0) ? 4'h0 : 4'(i % 8 + 3);
        exp_q.push_back(w);
        @(posedge ref_clk);
        rd_req <= 1'b0;
        if (i % 2 == 1)
        begin
            @(posedge ref_clk);
            rd_req <= 1'b1;
            rd_addr <= $random(seed);
            @(posedge ref_clk);
            rd_req <= 1'b0;
        end
    endtask : do_read
    // compare each captured word with the oldest note
    always @(posedge ref_clk)
        if (rst_b === 1'b1 && rd_done === 1'b1)
            if (exp_q.size() == 0) check(rd_data, ~rd_data);
            else check(rd_data, exp_q.pop_front());
    initial
    begin
        forever #10 ref_clk = ~ref_clk;
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        stop_test();
    end
    initial
    begin
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 40; i++)
            do_read(i);
        repeat (100) @(posedge ref_clk);
        if (exp_q.size() != 0) miscompares++;
        stop_test();
    end
endmodule : testbench
`default_nettype wire
